// ### core/spimsf_cfg.svh
`ifndef SPIMSF_CFG_SVH
`define SPIMSF_CFG_SVH

// ****************************************************************
// timing and sizing constants
// ****************************************************************
`define SPIMSF_FIFO_DEPTH 8
`define SPIMSF_CNT_W 4
`define SPIMSF_BITS_BYTE 5'h08
`define SPIMSF_BITS_WORD 5'h10
`define SPIMSF_CLK_PERIOD_NS 5
`define SPIMSF_RX_FULL_MARK 4'h8
`define SPIMSF_CFG_PPRE_LSB 0
`define SPIMSF_CFG_SPRE_LSB 2

`endif

// ### core/spimsf_pkg.sv
package spimsf_pkg;

    typedef struct packed {
        logic module_enable;
        logic master_select;
        logic fifo_mode_enable;
        logic ext_clock_select;
        logic slave_select_enable;
        logic clock_polarity;
        logic clock_edge;
        logic sample_phase;
        logic word16;
        logic [1:0] irq_mode_select;
        logic irq_enable;
        logic [1:0] primary_prescale;
        logic [2:0] secondary_prescale;
    } spimsf_cfg_t;

    typedef struct packed {
        logic tx_buffer_full;
        logic rx_buffer_full;
        logic rx_overflow;
        logic irq_flag;
        logic [3:0] buffer_element_count;
        logic busy;
    } spimsf_stat_t;

    typedef enum logic [1:0] {
        SPIMSF_IDLE = 2'b00,
        SPIMSF_LOAD = 2'b01,
        SPIMSF_SHIFT = 2'b10,
        SPIMSF_DONE = 2'b11
    } spimsf_state_t;

endpackage

// ### core/spimsf_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "spimsf_cfg.svh"

module spimsf_port
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // configuration and software strobes
    input wire spimsf_pkg::spimsf_cfg_t i_cfg,
    input wire logic i_wr,
    input wire logic [15:0] i_wdata,
    input wire logic i_rd,
    input wire logic i_clr_ovf,
    input wire logic i_clr_irq,
    // software read side
    output logic [15:0] o_rdata,
    output spimsf_pkg::spimsf_stat_t o_stat,
    output logic o_irq,
    // serial pins
    output logic o_shift_clock_pin,
    output logic o_shift_clock_pin_oe_n,
    input wire logic i_shift_clock_pin,
    output logic o_serial_out_pin,
    output logic o_serial_out_pin_oe_n,
    input wire logic i_serial_in_pin,
    input wire logic i_slave_select_pin_n
);
    import spimsf_pkg::*;

    localparam int DEPTH = `SPIMSF_FIFO_DEPTH;

    typedef struct packed {
        logic [DEPTH-1:0][15:0] txq;
        logic [2:0] tx_wp;
        logic [2:0] tx_rp;
        logic [3:0] tx_cnt;
        logic [DEPTH-1:0][15:0] rxq;
        logic [2:0] rx_wp;
        logic [2:0] rx_rp;
        logic [3:0] rx_cnt;
        logic [15:0] sr;
        logic [15:0] sr_word;
        logic sr_full;
        logic [4:0] bit_cnt;
        logic [6:0] div_cnt;
        logic sck;
        logic sdo;
        logic sdo_oe_n;
        logic sck_oe_n;
        logic [2:0] sck_sync;
        logic [1:0] sdi_sync;
        logic [1:0] ss_sync;
        logic tbf;
        logic rbf;
        logic ovf;
        logic irq_flag;
        logic irq;
        logic [3:0] bec;
        logic busy;
        logic [15:0] rdata;
        spimsf_state_t state;
    } spimsf_st_t;

    spimsf_st_t st_r;
    spimsf_st_t st_nxt;

    logic rx_in_ready;
    logic rx_out_valid;
    logic [15:0] rx_out_data;
    logic rx_in_valid;

    // ****************************************************************
    // received words pass through a two-entry buffer that always drains, so a
    // full rx fifo drops the word and sets overflow instead of stalling
    // ****************************************************************
    assign rx_in_valid = (st_r.state == SPIMSF_DONE);

    spimsf_skid u_skid
    (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_valid(rx_in_valid),
        .o_ready(rx_in_ready),
        .i_data(st_r.sr),
        .o_valid(rx_out_valid),
        .i_ready(1'b1),
        .o_data(rx_out_data)
    );

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb
    begin
        logic [4:0] nbits;
        logic [6:0] half;
        logic ext_clk;
        logic ss_ok;
        logic sck_rise;
        logic sck_fall;
        logic lead_edge;
        logic trail_edge;
        logic shift_edge;
        logic sample_edge;
        logic tx_pop;
        logic tx_push;
        logic rx_push;
        logic rx_pop;
        logic [3:0] tx_depth;
        nbits = i_cfg.word16 ? `SPIMSF_BITS_WORD : `SPIMSF_BITS_BYTE;
        half = 7'h00;
        ext_clk = 1'b0;
        ss_ok = 1'b1;
        sck_rise = 1'b0;
        sck_fall = 1'b0;
        lead_edge = 1'b0;
        trail_edge = 1'b0;
        shift_edge = 1'b0;
        sample_edge = 1'b0;
        tx_pop = 1'b0;
        tx_push = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        tx_depth = i_cfg.fifo_mode_enable ? 4'h8 : 4'h1;
        st_nxt = st_r;

        // clears come first so a set in the same cycle wins
        if (i_clr_ovf)
            st_nxt.ovf = 1'b0;
        if (i_clr_irq)
            st_nxt.irq_flag = 1'b0;

        // pins pass two flops before use
        st_nxt.sck_sync = {st_r.sck_sync[1:0], i_shift_clock_pin};
        st_nxt.sdi_sync = {st_r.sdi_sync[0], i_serial_in_pin};
        st_nxt.ss_sync = {st_r.ss_sync[0], i_slave_select_pin_n};

        ext_clk = !i_cfg.master_select || i_cfg.ext_clock_select;
        if (!i_cfg.master_select && i_cfg.slave_select_enable)
            ss_ok = !st_r.ss_sync[1];
        sck_rise = st_r.sck_sync[1] && !st_r.sck_sync[2];
        sck_fall = !st_r.sck_sync[1] && st_r.sck_sync[2];
        // leading edge leaves idle level
        lead_edge = i_cfg.clock_polarity ? sck_fall : sck_rise;
        trail_edge = i_cfg.clock_polarity ? sck_rise : sck_fall;

        // internal clock: half period from the two prescalers
        case (i_cfg.primary_prescale)
            2'h3: half = 7'h01;
            2'h2: half = 7'h04;
            2'h1: half = 7'h10;
            default: half = 7'h40;
        endcase
        half = 7'((32'(half) * (8 - 32'(i_cfg.secondary_prescale))) >> 1);
        if (half == 7'h00)
            half = 7'h01;

        // software write into tx path
        if (i_wr && i_cfg.module_enable && st_r.tx_cnt < tx_depth)
        begin
            tx_push = 1'b1;
            st_nxt.txq[st_r.tx_wp] = i_wdata;
            st_nxt.tx_wp = st_r.tx_wp + 3'h1;
        end

        // software read of the rx path
        if (i_rd && st_r.rx_cnt != 4'h0)
        begin
            rx_pop = 1'b1;
            st_nxt.rx_rp = st_r.rx_rp + 3'h1;
        end
        st_nxt.rdata = st_r.rxq[st_r.rx_rp];

        st_nxt.sdo_oe_n = !i_cfg.module_enable;
        st_nxt.sck_oe_n = !(i_cfg.module_enable && i_cfg.master_select && !i_cfg.ext_clock_select);

        case (st_r.state)
            SPIMSF_IDLE:
            begin
                st_nxt.sck = i_cfg.clock_polarity;
                st_nxt.div_cnt = 7'h00;
                if (i_cfg.module_enable && (st_r.tx_cnt != 4'h0 || st_r.sr_full || !i_cfg.master_select))
                    st_nxt.state = SPIMSF_LOAD;
            end
            SPIMSF_LOAD:
            begin
                if (!st_r.sr_full && st_r.tx_cnt != 4'h0)
                begin
                    tx_pop = 1'b1;
                    st_nxt.sr_word = st_r.txq[st_r.tx_rp];
                    st_nxt.tx_rp = st_r.tx_rp + 3'h1;
                    st_nxt.sr_full = 1'b1;
                end
                // reload from the held word so an abort can retry
                st_nxt.sr = tx_pop ? st_r.txq[st_r.tx_rp] : st_r.sr_word;
                st_nxt.sdo = i_cfg.word16 ? st_nxt.sr[15] : st_nxt.sr[7];
                st_nxt.bit_cnt = 5'h00;
                if (i_cfg.master_select && !tx_pop && !st_r.sr_full)
                    st_nxt.state = SPIMSF_IDLE;
                else if (ss_ok)
                    st_nxt.state = SPIMSF_SHIFT;
            end
            SPIMSF_SHIFT:
            begin
                if (!ext_clk)
                begin
                    // own pin echo must not count as a second edge
                    lead_edge = 1'b0;
                    trail_edge = 1'b0;
                    if (st_r.div_cnt + 7'h01 >= half)
                    begin
                        st_nxt.div_cnt = 7'h00;
                        st_nxt.sck = !st_r.sck;
                        lead_edge = (st_r.sck == i_cfg.clock_polarity);
                        trail_edge = !lead_edge;
                    end
                    else
                        st_nxt.div_cnt = st_r.div_cnt + 7'h01;
                end
                shift_edge = i_cfg.clock_edge ? trail_edge : lead_edge;
                sample_edge = i_cfg.clock_edge ? lead_edge : trail_edge;
                if (!ss_ok)
                    st_nxt.state = SPIMSF_LOAD;
                else
                begin
                    if (sample_edge)
                    begin
                        st_nxt.sr = {st_r.sr[14:0], st_r.sdi_sync[1]};
                        st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
                    end
                    if (shift_edge && st_r.bit_cnt != 5'h00)
                        st_nxt.sdo = i_cfg.word16 ? st_r.sr[15] : st_r.sr[7];
                    if (sample_edge && st_r.bit_cnt + 5'h01 == nbits)
                        st_nxt.state = SPIMSF_DONE;
                    // a word written before the first sample still gets loaded
                    if (!sample_edge && st_r.bit_cnt == 5'h00 && !st_r.sr_full && st_r.tx_cnt != 4'h0)
                        st_nxt.state = SPIMSF_LOAD;
                end
            end
            default:
            begin
                st_nxt.sck = i_cfg.clock_polarity;
                if (rx_in_ready)
                begin
                    st_nxt.sr_full = 1'b0;
                    st_nxt.state = SPIMSF_IDLE;
                end
            end
        endcase

        // serial output floats when deselected
        if (!ss_ok)
            st_nxt.sdo_oe_n = 1'b1;

        // rx fifo fill from the buffer
        if (rx_out_valid)
        begin
            if (st_r.rx_cnt == `SPIMSF_RX_FULL_MARK || (tx_depth == 4'h1 && st_r.rx_cnt != 4'h0 && !rx_pop))
            begin
                st_nxt.ovf = 1'b1;
                st_nxt.irq_flag = 1'b1;
            end
            else
            begin
                rx_push = 1'b1;
                st_nxt.rxq[st_r.rx_wp] = rx_out_data;
                st_nxt.rx_wp = st_r.rx_wp + 3'h1;
                if (i_cfg.irq_mode_select != 2'h3 || st_r.rx_cnt + 4'h1 == tx_depth)
                    st_nxt.irq_flag = 1'b1;
            end
        end
        st_nxt.tx_cnt = st_r.tx_cnt + {3'h0, tx_push} - {3'h0, tx_pop};
        st_nxt.rx_cnt = st_r.rx_cnt + {3'h0, rx_push} - {3'h0, rx_pop};

        // tx full: slave with select in non-fifo mode holds it until shift completes
        if (!i_cfg.master_select && i_cfg.slave_select_enable && tx_depth == 4'h1)
            st_nxt.tbf = (st_nxt.tx_cnt != 4'h0) || st_nxt.sr_full;
        else
            st_nxt.tbf = (st_nxt.tx_cnt >= tx_depth);
        if (i_cfg.fifo_mode_enable && st_nxt.tx_cnt == 4'h8 && tx_push)
            st_nxt.irq_flag = 1'b1;
        st_nxt.rbf = (st_nxt.rx_cnt >= tx_depth);

        st_nxt.irq = st_nxt.irq_flag && i_cfg.irq_enable;
        if (!i_cfg.module_enable)
            st_nxt.state = SPIMSF_IDLE;
        st_nxt.bec = i_cfg.master_select ? st_nxt.tx_cnt : st_nxt.rx_cnt;
        st_nxt.busy = (st_nxt.state != SPIMSF_IDLE);
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st_r <= '0;
            st_r.sdo_oe_n <= 1'b1;
            st_r.sck_oe_n <= 1'b1;
            st_r.ss_sync <= 2'b11;
        end
        else
            st_r <= st_nxt;
    end

    // ****************************************************************
    // outputs straight from flops
    // ****************************************************************
    assign o_rdata = st_r.rdata;
    assign o_irq = st_r.irq;
    assign o_shift_clock_pin = st_r.sck;
    assign o_shift_clock_pin_oe_n = st_r.sck_oe_n;
    assign o_serial_out_pin = st_r.sdo;
    assign o_serial_out_pin_oe_n = st_r.sdo_oe_n;
    assign o_stat.tx_buffer_full = st_r.tbf;
    assign o_stat.rx_buffer_full = st_r.rbf;
    assign o_stat.rx_overflow = st_r.ovf;
    assign o_stat.irq_flag = st_r.irq_flag;
    assign o_stat.buffer_element_count = st_r.bec;
    assign o_stat.busy = st_r.busy;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_irq_sticky: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        st_r.irq_flag && !i_clr_irq |=> st_r.irq_flag) else $error("irq flag self-cleared");
    a_ovf_sets_irq: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $rose(st_r.ovf) |-> st_r.irq_flag) else $error("overflow without irq");
    a_ss_tristate: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !i_cfg.master_select && i_cfg.slave_select_enable && st_r.ss_sync[1] |=> st_r.sdo_oe_n)
        else $error("output driven while deselected");
    a_tx_cap: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        st_r.tx_cnt <= 4'h8) else $error("tx count past eight");
    a_rx_cap: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        st_r.rx_cnt <= 4'h8) else $error("rx count past eight");
    a_rd_empty: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_rd && st_r.rx_cnt == 4'h0 |=> $stable(st_r.rx_rp)) else $error("read advanced past last");
    a_tbf_fifo: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_cfg.fifo_mode_enable && st_r.tx_cnt == 4'h8 |-> st_r.tbf) else $error("tx full missing");
    a_sck_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        st_r.state == SPIMSF_IDLE ##1 st_r.state == SPIMSF_IDLE |-> st_r.sck == $past(i_cfg.clock_polarity))
        else $error("clock not idle level");
endmodule // spimsf_port

`default_nettype wire

// ### core/spimsf_skid.sv
`timescale 1ns/1ps
`default_nettype none

// two-entry buffer in the received-data path
module spimsf_skid
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // fill side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [15:0] i_data,
    // drain side
    output logic o_valid,
    input wire logic i_ready,
    output logic [15:0] o_data
);
    import spimsf_pkg::*;

    typedef struct packed {
        logic [1:0][15:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } spimsf_skid_st_t;

    spimsf_skid_st_t st_r;
    spimsf_skid_st_t st_nxt;
    logic push;
    logic pop;

    assign o_ready = (st_r.cnt != 2'h2);
    assign o_valid = (st_r.cnt != 2'h0);
    assign o_data = st_r.mem[st_r.rp];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wp] = i_data;
            st_nxt.wp = ~st_r.wp;
        end
        if (pop)
            st_nxt.rp = ~st_r.rp;
        st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
endmodule // spimsf_skid

`default_nettype wire

// ### verif/spi_master_slave_fifo_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module spi_master_slave_fifo_port_tb_top;
    import spimsf_pkg::*;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    spimsf_cfg_t cfg = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic clr_ovf = 1'b0;
    logic clr_irq = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    spimsf_stat_t stat;
    logic irq, sck_o, sck_oe_n, sdo_o, sdo_oe_n, far_sck, far_ss_n, far_sdo;
    logic sdo_hold = 1'b0;
    logic [15:0] mask = 16'h00ff;
    logic [15:0] k;
    int n_mismatch = 0;
    int n_compared = 0;
    // released data line shows the inverse of its last driven bit
    wire logic sck_line = sck_oe_n ? far_sck : sck_o;
    wire logic sdo_line = sdo_oe_n ? ~sdo_hold : sdo_o;

    always_ff @(posedge i_clk)
        if (!sdo_oe_n) sdo_hold <= sdo_o;

    spimsf_port dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cfg(cfg), .i_wr(i_wr), .i_wdata(wdata),
        .i_rd(i_rd), .i_clr_ovf(clr_ovf), .i_clr_irq(clr_irq), .o_rdata(rdata), .o_stat(stat), .o_irq(irq),
        .o_shift_clock_pin(sck_o), .o_shift_clock_pin_oe_n(sck_oe_n), .i_shift_clock_pin(sck_line),
        .o_serial_out_pin(sdo_o), .o_serial_out_pin_oe_n(sdo_oe_n), .i_serial_in_pin(far_sdo),
        .i_slave_select_pin_n(far_ss_n));

    spimsf_far_end far (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cpol(cfg.clock_polarity),
        .i_sck_line(sck_line), .i_sdi_line(sdo_line), .o_sck(far_sck), .o_ss_n(far_ss_n), .o_sdo(far_sdo));

    initial
    begin
        forever #2.5 i_clk = ~i_clk;
    end

    // ****************************************
    // access tasks
    // ****************************************
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    // disable, configure, clear flags, enable, then empty the receive side
    task automatic setcfg(input logic m, f, x, s, p, e, w);
        spimsf_cfg_t c;
        c = '0;
        c.master_select = m;
        c.fifo_mode_enable = f;
        c.ext_clock_select = x;
        c.slave_select_enable = s;
        c.clock_polarity = p;
        c.clock_edge = e;
        c.word16 = w;
        c.irq_enable = 1'b1;
        c.primary_prescale = 2'h1;
        c.secondary_prescale = 3'h7;
        cfg <= c;
        clr_ovf <= 1'b1;
        clr_irq <= 1'b1;
        @(posedge i_clk);
        clr_ovf <= 1'b0;
        clr_irq <= 1'b0;
        c.module_enable = 1'b1;
        cfg <= c;
        i_rd <= 1'b1;
        repeat (10) @(posedge i_clk);
        i_rd <= 1'b0;
        mask <= w ? 16'hffff : 16'h00ff;
        far.sync_up(w ? 16 : 8);
        repeat (3) @(posedge i_clk);
        k = far.n_frames;
    endtask

    task automatic wrn(input int n, input logic [15:0] base);
        i_wr <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            wdata <= base + 16'(i);
            @(posedge i_clk);
        end
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic rd(input logic [15:0] exp);
        chk("rdata", rdata & mask, exp & mask);
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask

    task automatic wait_frames(input int n);
        for (int i = 0; i < 6000 && far.rxq.size() < n; i++)
            @(posedge i_clk);
        repeat (12) @(posedge i_clk);
        chk("frames", 16'(far.rxq.size()), 16'(n));
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        summarize();
    end

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        repeat (10) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        setcfg(1, 0, 0, 0, 0, 0, 0);
        chk("sck idle", 16'(sck_o), 16'h0000);
        wrn(1, 16'h00a5);
        wait_frames(1);
        chk("far rx", far.rxq[0] & mask, 16'h00a5);
        chk("rx full", 16'(stat.rx_buffer_full), 16'h0001);
        chk("irq out", 16'(irq), 16'h0001);
        rd(16'hc3a0 + k);
        chk("rx full", 16'(stat.rx_buffer_full), 16'h0000);
        chk("irq kept", 16'(stat.irq_flag), 16'h0001);
        wrn(1, 16'h005a);
        wait_frames(2);
        wrn(1, 16'h0011);
        wait_frames(3);
        chk("overflow", 16'(stat.rx_overflow), 16'h0001);
        rd(16'hc3a1 + k);
        $display("test legacy master done");

        setcfg(1, 1, 0, 0, 1, 0, 1);
        chk("sck idle", 16'(sck_o), 16'h0001);
        wrn(9, 16'h1230);
        repeat (2) @(posedge i_clk);
        chk("count", 16'(stat.buffer_element_count), 16'h0008);
        chk("tx full", 16'(stat.tx_buffer_full), 16'h0001);
        chk("irq flag", 16'(stat.irq_flag), 16'h0001);
        wrn(1, 16'hdead);
        wait_frames(9);
        for (int i = 0; i < 40; i++)
        begin
            chk("sck idle", 16'(sck_o), 16'h0001);
            @(posedge i_clk);
        end
        chk("frames", 16'(far.rxq.size()), 16'h0009);
        chk("count", 16'(stat.buffer_element_count), 16'h0000);
        chk("tx full", 16'(stat.tx_buffer_full), 16'h0000);
        chk("rx full", 16'(stat.rx_buffer_full), 16'h0001);
        chk("overflow", 16'(stat.rx_overflow), 16'h0001);
        for (int i = 0; i < 9; i++)
            chk("far rx", far.rxq[i], 16'h1230 + 16'(i));
        for (int i = 0; i < 8; i++)
            rd(16'hc3a0 + k + 16'(i));
        $display("test fifo master done");

        setcfg(1, 0, 1, 0, 0, 0, 0);
        wrn(1, 16'h0096);
        repeat (60) @(posedge i_clk);
        chk("sck oe_n", 16'(sck_oe_n), 16'h0001);
        chk("rx full", 16'(stat.rx_buffer_full), 16'h0000);
        far.frame(8, 99, 1'b0);
        wait_frames(1);
        chk("far rx", far.rxq[0] & mask, 16'h0096);
        rd(16'hc3a0 + k);
        $display("test external clock done");

        setcfg(0, 0, 0, 1, 0, 0, 0);
        wrn(1, 16'h00c6);
        chk("tx full", 16'(stat.tx_buffer_full), 16'h0001);
        far.frame(8, 99, 1'b0);
        repeat (6) @(posedge i_clk);
        chk("rx full", 16'(stat.rx_buffer_full), 16'h0000);
        far.sync_up(8);
        fork
            far.frame(8, 3, 1'b1);
            begin
                repeat (24) @(posedge i_clk);
                chk("sdo oe_n", 16'(sdo_oe_n), 16'h0000);
            end
        join
        repeat (4) @(posedge i_clk);
        chk("sdo oe_n", 16'(sdo_oe_n), 16'h0001);
        chk("tx full", 16'(stat.tx_buffer_full), 16'h0001);
        far.sync_up(8);
        k = far.n_frames;
        far.frame(8, 99, 1'b1);
        wait_frames(1);
        chk("far rx", far.rxq[0] & mask, 16'h00c6);
        chk("tx full", 16'(stat.tx_buffer_full), 16'h0000);
        rd(16'hc3a0 + k);
        $display("test slave select done");

        setcfg(0, 1, 0, 0, 0, 0, 0);
        wrn(1, 16'h0033);
        repeat (6) @(posedge i_clk);
        chk("tx full", 16'(stat.tx_buffer_full), 16'h0000);
        far.frame(8, 99, 1'b0);
        wait_frames(1);
        chk("far rx", far.rxq[0] & mask, 16'h0033);
        chk("count", 16'(stat.buffer_element_count), 16'h0001);
        rd(16'hc3a0 + k);
        $display("test free slave done");
        summarize();
    end
endmodule // spi_master_slave_fifo_port_tb_top

`default_nettype wire

// ### verif/spimsf_far_end.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// far end: follows or makes the shift clock
// ****************************************
module spimsf_far_end
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // pin levels
    input wire logic i_cpol,
    input wire logic i_sck_line,
    input wire logic i_sdi_line,
    output logic o_sck,
    output logic o_ss_n,
    output logic o_sdo
);
    int nb = 8;
    int cnt = 0;
    logic [15:0] n_frames = 16'h0000;
    logic [15:0] tx = 16'hc3a0;
    logic [15:0] rx = 16'h0000;
    logic [15:0] rxq[$];

    initial
    begin
        o_sck = 1'b0;
        o_ss_n = 1'b1;
        o_sdo = 1'b0;
    end

    // the idle level moves first, so that move is not counted as an edge
    task automatic sync_up(input int n);
        o_sck <= i_cpol;
        @(posedge i_clk);
        nb = n;
        cnt = 0;
        tx = 16'hc3a0 + n_frames;
        rxq.delete();
    endtask

    // clock levels last 8 cycles, above the 3 the port needs to see them
    task automatic frame(input int n, input int abort_at, input logic use_ss);
        if (use_ss)
        begin
            o_ss_n <= 1'b0;
        end
        for (int i = 0; i < n && i != abort_at; i++)
        begin
            repeat (8) @(posedge i_clk);
            o_sck <= ~i_cpol;
            repeat (8) @(posedge i_clk);
            o_sck <= i_cpol;
        end
        repeat (8) @(posedge i_clk);
        o_ss_n <= 1'b1;
    endtask

    // an aborted frame restarts with the same word
    always @(posedge o_ss_n)
    begin
        cnt = 0;
        tx = 16'hc3a0 + n_frames;
    end

    // data leaves on the leading edge and is taken on the trailing edge, msb first
    always @(i_sck_line)
    begin
        if (i_arst_n && i_sck_line != i_cpol)
        begin
            o_sdo <= tx[nb-1];
            tx = tx << 1;
        end
        else if (i_arst_n)
        begin
            rx = {rx[14:0], i_sdi_line};
            cnt++;
            if (cnt == nb)
            begin
                rxq.push_back(rx);
                cnt = 0;
                n_frames++;
                tx = 16'hc3a0 + n_frames;
            end
        end
    end
endmodule // spimsf_far_end

`default_nettype wire
